// File: comparator_subsystem.sv
// Comparator subsystem: trip latch, ramp generator, AHB-Lite registers
`timescale 1ns/100ps
`default_nettype none
module comparator_subsystem #(
    parameter int WIN = 16 // Filter history depth
) (
    input wire logic CLK_IN, // Module clock, 50 MHz
    input wire logic RST_N_IN, // Synchronous reset, low
    input wire logic HSEL_IN, // AHB select
    input wire logic [31:0] HADDR_IN, // AHB address
    input wire logic [1:0] HTRANS_IN, // AHB transfer type
    input wire logic HWRITE_IN, // AHB write
    input wire logic [2:0] HSIZE_IN, // AHB size, word only
    input wire logic HREADY_IN, // AHB bus ready
    input wire logic [31:0] HWDATA_IN, // AHB write data
    output logic [31:0] HRDATA_OUT, // AHB read data
    output logic HREADYOUT_OUT, // AHB slave ready
    output logic HRESP_OUT, // AHB response, OKAY
    input wire logic COMP_HIGH_IN, // High comparator level
    input wire logic SYNC_IN, // period_sync_pulse
    output logic [cmp_pkg::DAC_W-1:0] DAC_VALUE_OUT, // Ramp DAC reference
    output logic TRIP_LATCH_OUT, // trip_latch state
    output logic IRQ_OUT // Interrupt level
);
    localparam int DW = cmp_pkg::DAC_W;
    localparam int IW = cmp_pkg::IRQ_W;

    logic wr_pend_reg;
    logic [7:0] wr_addr_reg;
    logic [31:0] rdata_reg;
    logic latch_reg;
    logic latch_next;
    logic run_reg;
    logic run_next;
    logic [DW-1:0] dac_reg;
    logic [DW-1:0] dac_next;
    logic [DW-1:0] start_reg;
    logic [DW-1:0] step_reg;
    logic [cmp_pkg::PRE_W-1:0] div_reg;
    logic [cmp_pkg::THR_W-1:0] thr_reg;
    logic [IW-1:0] irq_sts_reg;
    logic [IW-1:0] irq_en_reg;
    logic [IW-1:0] irq_clr;
    logic [IW-1:0] irq_ev;
    logic filt_out;
    logic filt_init;
    logic sts_clr;
    logic addr_ok;
    logic [31:0] status_word;

    // Data phase write hit on one register
    function automatic logic wr_hit(input logic pend, input logic [7:0] a,
                                    input logic [7:0] off);
        return pend && (a == off);
    endfunction

    // ------------------------------------------------------------
    // AHB-Lite slave
    // ------------------------------------------------------------
    // Zero wait states, always OKAY
    assign HREADYOUT_OUT = 1'b1;
    assign HRESP_OUT = 1'b0;
    assign HRDATA_OUT = rdata_reg;
    assign addr_ok = HSEL_IN && HTRANS_IN[1] && HREADY_IN;

    // Address phase capture for writes
    always_ff @(posedge CLK_IN)
    begin
        if (!RST_N_IN)
        begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
        end
        else
        begin
            wr_pend_reg <= addr_ok && HWRITE_IN;
            wr_addr_reg <= HADDR_IN[7:0];
        end
    end

    // Status word shows latch, live filter output, ramp state
    always_comb
    begin
        status_word = 32'h0000_0000;
        status_word[cmp_pkg::STS_LATCH_BIT] = latch_reg;
        status_word[cmp_pkg::STS_FILT_BIT] = filt_out;
        status_word[cmp_pkg::STS_RAMP_BIT] = run_reg;
    end

    // Read data registered at the address phase; unmapped reads zero
    always_ff @(posedge CLK_IN)
    begin
        if (!RST_N_IN)
            rdata_reg <= 32'h0000_0000;
        else if (addr_ok && !HWRITE_IN)
        begin
            case (HADDR_IN[7:0])
                cmp_pkg::OFF_STATUS: rdata_reg <= status_word;
                cmp_pkg::OFF_FILT_CTRL: rdata_reg <= {19'h00000, thr_reg, div_reg};
                cmp_pkg::OFF_RAMP_START: rdata_reg <= {16'h0000, start_reg};
                cmp_pkg::OFF_RAMP_STEP: rdata_reg <= {16'h0000, step_reg};
                cmp_pkg::OFF_DAC: rdata_reg <= {16'h0000, dac_reg};
                cmp_pkg::OFF_IRQ_STS: rdata_reg <= {30'h00000000, irq_sts_reg};
                cmp_pkg::OFF_IRQ_EN: rdata_reg <= {30'h00000000, irq_en_reg};
                default: rdata_reg <= 32'h0000_0000;
            endcase
        end
    end

    // Write strobes with side effects
    assign sts_clr = wr_hit(wr_pend_reg, wr_addr_reg, cmp_pkg::OFF_STS_CLR)
                     && HWDATA_IN[cmp_pkg::STS_LATCH_BIT];
    assign filt_init = wr_hit(wr_pend_reg, wr_addr_reg, cmp_pkg::OFF_FILT_CTRL)
                       && HWDATA_IN[cmp_pkg::INIT_BIT];
    assign irq_clr = wr_hit(wr_pend_reg, wr_addr_reg, cmp_pkg::OFF_IRQ_CLR)
                     ? HWDATA_IN[IW-1:0] : '0;

    // Configuration registers
    always_ff @(posedge CLK_IN)
    begin
        if (!RST_N_IN)
        begin
            div_reg <= cmp_pkg::PRE_RST;
            thr_reg <= cmp_pkg::THR_RST;
            start_reg <= cmp_pkg::RAMP_START_RST;
            step_reg <= cmp_pkg::RAMP_STEP_RST;
            irq_en_reg <= cmp_pkg::IRQ_EN_RST;
        end
        else
        begin
            if (wr_hit(wr_pend_reg, wr_addr_reg, cmp_pkg::OFF_FILT_CTRL))
            begin
                div_reg <= HWDATA_IN[cmp_pkg::PRE_LSB +: cmp_pkg::PRE_W];
                thr_reg <= HWDATA_IN[cmp_pkg::THR_LSB +: cmp_pkg::THR_W];
            end
            if (wr_hit(wr_pend_reg, wr_addr_reg, cmp_pkg::OFF_RAMP_START))
                start_reg <= HWDATA_IN[DW-1:0];
            if (wr_hit(wr_pend_reg, wr_addr_reg, cmp_pkg::OFF_RAMP_STEP))
                step_reg <= HWDATA_IN[DW-1:0];
            if (wr_hit(wr_pend_reg, wr_addr_reg, cmp_pkg::OFF_IRQ_EN))
                irq_en_reg <= HWDATA_IN[IW-1:0];
        end
    end

    // ------------------------------------------------------------
    // Filter and trip latch
    // ------------------------------------------------------------
    trip_filter #(
        .WIN(WIN)
    ) u_filter (
        .CLK_IN(CLK_IN),
        .RST_N_IN(RST_N_IN),
        .sample_in(COMP_HIGH_IN),
        .div_in(div_reg),
        .thr_in(thr_reg),
        .flush_in(filt_init),
        .out_out(filt_out)
    );

    // Clear wins this cycle; a filter still high sets it next cycle
    always_comb
    begin
        if (sts_clr || SYNC_IN)
            latch_next = 1'b0;
        else if (filt_out)
            latch_next = 1'b1;
        else
            latch_next = latch_reg;
    end

    always_ff @(posedge CLK_IN)
    begin
        if (!RST_N_IN)
            latch_reg <= 1'b0;
        else
            latch_reg <= latch_next;
    end

    assign TRIP_LATCH_OUT = latch_reg;

    // ------------------------------------------------------------
    // Ramp generator
    // ------------------------------------------------------------
    // Sync reloads and runs; latched trip stops and holds
    always_comb
    begin
        run_next = run_reg;
        dac_next = dac_reg;
        if (SYNC_IN)
        begin
            run_next = 1'b1;
            dac_next = start_reg;
        end
        else if (latch_reg)
            run_next = 1'b0;
        else if (run_reg)
            dac_next = (dac_reg > step_reg) ? dac_reg - step_reg : '0;
    end

    always_ff @(posedge CLK_IN)
    begin
        if (!RST_N_IN)
        begin
            run_reg <= 1'b0;
            dac_reg <= cmp_pkg::RAMP_START_RST;
        end
        else
        begin
            run_reg <= run_next;
            dac_reg <= dac_next;
        end
    end

    assign DAC_VALUE_OUT = dac_reg;

    // ------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------
    // Sticky events; a new event beats a clear
    always_comb
    begin
        irq_ev = '0;
        irq_ev[cmp_pkg::IRQ_TRIP_BIT] = latch_next && !latch_reg;
        irq_ev[cmp_pkg::IRQ_SYNC_BIT] = SYNC_IN;
    end

    always_ff @(posedge CLK_IN)
    begin
        if (!RST_N_IN)
            irq_sts_reg <= '0;
        else
            irq_sts_reg <= (irq_sts_reg & ~irq_clr) | irq_ev;
    end

    assign IRQ_OUT = |(irq_sts_reg & irq_en_reg);

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (!RST_N_IN);

    sequence s_sync;
        SYNC_IN;
    endsequence
    sequence s_ramp_down;
        run_reg && !latch_reg && !SYNC_IN && dac_reg > step_reg;
    endsequence

    property p_sync_starts;
        s_sync |=> run_reg && dac_reg == $past(start_reg);
    endproperty
    a_sync_starts: assert property (p_sync_starts)
        else $error("sync did not start ramp");

    property p_ramp_falls;
        s_ramp_down |=> dac_reg == $past(dac_reg) - $past(step_reg);
    endproperty
    a_ramp_falls: assert property (p_ramp_falls)
        else $error("ramp did not step down");

    property p_trip_holds;
        latch_reg && !SYNC_IN ##1 !SYNC_IN |=> !run_reg && $stable(dac_reg);
    endproperty
    a_trip_holds: assert property (p_trip_holds)
        else $error("ramp moved after trip");

    property p_sync_wins;
        s_sync and latch_reg |=> run_reg;
    endproperty
    a_sync_wins: assert property (p_sync_wins)
        else $error("trip beat sync");

    property p_clear;
        sts_clr || SYNC_IN |=> !latch_reg;
    endproperty
    a_clear: assert property (p_clear)
        else $error("latch not cleared");

    property p_hold;
        latch_reg && !sts_clr && !SYNC_IN |=> latch_reg;
    endproperty
    a_hold: assert property (p_hold)
        else $error("latch dropped without clear");

    property p_set_cause;
        $rose(latch_reg) |-> $past(filt_out);
    endproperty
    a_set_cause: assert property (p_set_cause)
        else $error("latch set without filter");

    property p_reset_again;
        (sts_clr && filt_out) ##1 (filt_out && !sts_clr && !SYNC_IN) |=> latch_reg;
    endproperty
    a_reset_again: assert property (p_reset_again)
        else $error("latch not set again");

    property p_status_live;
        addr_ok && !HWRITE_IN && HADDR_IN[7:0] == cmp_pkg::OFF_STATUS
            |=> HRDATA_OUT[cmp_pkg::STS_FILT_BIT] == $past(filt_out);
    endproperty
    a_status_live: assert property (p_status_live)
        else $error("status lacks filter state");
endmodule // comparator_subsystem
`default_nettype wire

// File: cmp_pkg.sv
// Constants shared by the comparator trip latch, filter and ramp logic
`default_nettype none
package cmp_pkg;
    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_STATUS = 8'h00;
    localparam logic [7:0] OFF_STS_CLR = 8'h04;
    localparam logic [7:0] OFF_FILT_CTRL = 8'h08;
    localparam logic [7:0] OFF_RAMP_START = 8'h0C;
    localparam logic [7:0] OFF_RAMP_STEP = 8'h10;
    localparam logic [7:0] OFF_DAC = 8'h14;
    localparam logic [7:0] OFF_IRQ_STS = 8'h18;
    localparam logic [7:0] OFF_IRQ_CLR = 8'h1C;
    localparam logic [7:0] OFF_IRQ_EN = 8'h20;
    // ------------------------------------------------------------
    // Field positions and widths
    // ------------------------------------------------------------
    localparam int STS_LATCH_BIT = 0;
    localparam int STS_FILT_BIT = 1;
    localparam int STS_RAMP_BIT = 2;
    localparam int PRE_LSB = 0;
    localparam int PRE_W = 8;
    localparam int THR_LSB = 8;
    localparam int THR_W = 5;
    localparam int INIT_BIT = 16;
    localparam int IRQ_TRIP_BIT = 0;
    localparam int IRQ_SYNC_BIT = 1;
    localparam int IRQ_W = 2;
    localparam int DAC_W = 16;
    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [PRE_W-1:0] PRE_RST = 8'h01;
    localparam logic [THR_W-1:0] THR_RST = 5'h01;
    localparam logic [DAC_W-1:0] RAMP_START_RST = 16'hFFFF;
    localparam logic [DAC_W-1:0] RAMP_STEP_RST = 16'h0001;
    localparam logic [IRQ_W-1:0] IRQ_EN_RST = 2'h0;
endpackage
`default_nettype wire

// File: trip_filter.sv
// Digital vote filter that qualifies the comparator output
`timescale 1ns/100ps
`default_nettype none
module trip_filter #(
    parameter int WIN = 16 // Deepest sample history
) (
    input wire logic CLK_IN, // Module clock
    input wire logic RST_N_IN, // Synchronous reset, low
    input wire logic sample_in, // Raw comparator level
    input wire logic [cmp_pkg::PRE_W-1:0] div_in, // filter_sample_divider
    input wire logic [cmp_pkg::THR_W-1:0] thr_in, // filter_vote_threshold
    input wire logic flush_in, // Reinit pulse
    output logic out_out // Qualified level
);
    logic [cmp_pkg::PRE_W-1:0] div_cnt_reg;
    logic [WIN-1:0] hist_reg;
    logic [WIN-1:0] vld_reg;
    logic [WIN-1:0] hist_next;
    logic [WIN-1:0] vld_next;
    logic [WIN-1:0] m;
    logic tick;
    logic [cmp_pkg::PRE_W-1:0] div_eff;

    // Mask of the newest n+1 samples, bit 0 always set
    function automatic logic [WIN-1:0] low_mask(input logic [cmp_pkg::THR_W-1:0] n);
        logic [WIN-1:0] r;
        r = '0;
        for (int i = 0; i < WIN; i++)
            r[i] = (i <= int'(n)) || (i == 0);
        return r;
    endfunction

    // Sample strobe every divider cycles, zero acts as one
    assign div_eff = (div_in == '0) ? cmp_pkg::PRE_W'(1) : div_in;
    assign tick = (div_cnt_reg >= div_eff - cmp_pkg::PRE_W'(1));
    assign m = low_mask(thr_in);

    // History as it stands after this edge; one new sample per strobe
    assign hist_next = tick ? {hist_reg[WIN-2:0], sample_in} : hist_reg;
    assign vld_next = tick ? {vld_reg[WIN-2:0], 1'b1} : vld_reg;

    // Prescale counter, restarted by reinit
    always_ff @(posedge CLK_IN)
    begin
        if (!RST_N_IN || flush_in || tick)
            div_cnt_reg <= '0;
        else
            div_cnt_reg <= div_cnt_reg + cmp_pkg::PRE_W'(1);
    end

    // Sample history; reinit empties it
    always_ff @(posedge CLK_IN)
    begin
        if (!RST_N_IN || flush_in)
        begin
            hist_reg <= '0;
            vld_reg <= '0;
        end
        else
        begin
            hist_reg <= hist_next;
            vld_reg <= vld_next;
        end
    end

    // Output flips once threshold+1 valid samples agree
    // Votes on the history being written, so no extra cycle is spent after the last sample
    always_ff @(posedge CLK_IN)
    begin
        if (!RST_N_IN || flush_in)
            out_out <= 1'b0;
        else if ((vld_next & m) == m && (hist_next & m) == m)
            out_out <= 1'b1;
        else if ((vld_next & m) == m && (hist_next & m) == '0)
            out_out <= 1'b0;
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (!RST_N_IN);

    property p_flush_empties;
        flush_in |=> (vld_reg == '0) && !out_out;
    endproperty
    a_flush_empties: assert property (p_flush_empties)
        else $error("filter history not flushed");

    property p_rise_needs_votes;
        $rose(out_out) |-> $past((hist_next & m) == m);
    endproperty
    a_rise_needs_votes: assert property (p_rise_needs_votes)
        else $error("filter rose without full vote");
endmodule // trip_filter
`default_nettype wire

// File: pwm_sync_model.sv
// PWM timer model that issues the period sync pulse
`timescale 1ns/100ps
`default_nettype none
module pwm_sync_model (
    input wire logic CLK_IN, // Module clock
    input wire logic RST_N_IN, // Synchronous reset, low
    input wire logic req_in, // Pulse request from the bench
    output logic sync_out // period_sync_pulse, one cycle wide
);
    // ------------------------------------------------------------
    // Sync pulse
    // ------------------------------------------------------------
    // One-cycle pulse on the edge after each request cycle, low otherwise
    always_ff @(posedge CLK_IN)
    begin
        if (!RST_N_IN)
            sync_out <= 1'b0;
        else
            sync_out <= req_in;
    end
endmodule // pwm_sync_model
`default_nettype wire

// File: comparator_trip_latch_and_ramp_tb.sv
// Self-checking testbench for the comparator subsystem
`timescale 1ns/100ps
`default_nettype none
module comparator_trip_latch_and_ramp_tb;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic clk, rst_n, hsel, hwrite, comp, req, sync, hreadyout, hresp, latch, irq;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [15:0] dac;
    int failures, total_checks;

    // ------------------------------------------------------------
    // Design and far-side model
    // ------------------------------------------------------------
    comparator_subsystem #(.WIN(16)) dut (
        .CLK_IN(clk), .RST_N_IN(rst_n), .HSEL_IN(hsel), .HADDR_IN(haddr),
        .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(hsize),
        .HREADY_IN(hreadyout), .HWDATA_IN(hwdata), .HRDATA_OUT(hrdata),
        .HREADYOUT_OUT(hreadyout), .HRESP_OUT(hresp), .COMP_HIGH_IN(comp),
        .SYNC_IN(sync), .DAC_VALUE_OUT(dac), .TRIP_LATCH_OUT(latch), .IRQ_OUT(irq)
    );
    pwm_sync_model pwm (.CLK_IN(clk), .RST_N_IN(rst_n), .req_in(req), .sync_out(sync));

    // ------------------------------------------------------------
    // Clock and watchdog
    // ------------------------------------------------------------
    // 50 MHz module clock
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // Cuts a hang short after 20k cycles, far beyond the few hundred the tests need
    initial
    begin
        #400000;
        failures++;
        summarize();
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic check_word(input string name, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic check_bit(input string name, input logic exp, input logic got);
        total_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("mismatch %s expected %b seen %b", name, exp, got);
        end
    endtask
    // One single word transfer; read data lands in rd at the data-phase edge
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        htrans <= 2'h2;
        haddr <= {24'h000000, a};
        hwrite <= wr;
        @(posedge clk);
        while (hreadyout !== 1'b1)
            @(posedge clk);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clk);
        while (hreadyout !== 1'b1)
            @(posedge clk);
        rd = hrdata;
    endtask
    task automatic expect_reg(input string name, input logic [7:0] a, input logic [31:0] exp);
        ahb(1'b0, a, 32'h00000000);
        check_word(name, exp, rd);
    endtask
    // Waits n edges, then samples just after the last one
    task automatic edges(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Asks the PWM model for a pulse; returns just after the edge that takes it
    task automatic pulse_sync();
        @(posedge clk);
        req <= 1'b1;
        @(posedge clk);
        req <= 1'b0;
        edges(1);
    endtask
    // Drops the trip, waits for the filter to read low, then clears the latch
    task automatic settle_clear();
        int n;
        n = 0;
        comp <= 1'b0;
        do
        begin
            ahb(1'b0, cmp_pkg::OFF_STATUS, 32'h00000000);
            n++;
        end
        while (rd[cmp_pkg::STS_FILT_BIT] !== 1'b0 && n < 50);
        check_bit("filter low before clear", 1'b0, rd[cmp_pkg::STS_FILT_BIT]);
        ahb(1'b1, cmp_pkg::OFF_STS_CLR, 32'h00000001);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        check_bit("latch at reset", 1'b0, latch);
        check_bit("irq at reset", 1'b0, irq);
        check_bit("hresp okay", 1'b0, hresp);
        check_word("dac at reset", 32'h0000FFFF, {16'h0000, dac});
        expect_reg("status", cmp_pkg::OFF_STATUS, 32'h00000000);
        expect_reg("filter ctrl", cmp_pkg::OFF_FILT_CTRL, 32'h00000101);
        expect_reg("ramp start", cmp_pkg::OFF_RAMP_START, 32'h0000FFFF);
        expect_reg("ramp step", cmp_pkg::OFF_RAMP_STEP, 32'h00000001);
        expect_reg("irq enable", cmp_pkg::OFF_IRQ_EN, 32'h00000000);
        expect_reg("unmapped", 8'h40, 32'h00000000);
        ahb(1'b1, cmp_pkg::OFF_DAC, 32'h00000000);
        expect_reg("dac read-only", cmp_pkg::OFF_DAC, 32'h0000FFFF);
    endtask
    task automatic t_ramp();
        ahb(1'b1, cmp_pkg::OFF_RAMP_START, 32'h00000100);
        ahb(1'b1, cmp_pkg::OFF_RAMP_STEP, 32'h00000004);
        pulse_sync();
        check_word("dac at sync", 32'h00000100, {16'h0000, dac});
        edges(5);
        check_word("dac falling", 32'h000000EC, {16'h0000, dac});
        expect_reg("ramp running", cmp_pkg::OFF_STATUS, 32'h00000004);
    endtask
    task automatic t_trip_hold();
        logic [15:0] held;
        comp <= 1'b1;
        edges(4);
        check_bit("latch on trip", 1'b1, latch);
        comp <= 1'b0;
        edges(2);
        held = dac;
        edges(10);
        check_word("dac held", {16'h0000, held}, {16'h0000, dac});
        expect_reg("ramp stopped", cmp_pkg::OFF_STATUS, 32'h00000001);
    endtask
    task automatic t_sync_wins();
        comp <= 1'b1;
        edges(4);
        pulse_sync();
        check_bit("latch after sync", 1'b0, latch);
        check_word("dac reload", 32'h00000100, {16'h0000, dac});
        edges(1);
        check_bit("latch re-set", 1'b1, latch);
        edges(2);
        check_word("dac one step", 32'h000000FC, {16'h0000, dac});
    endtask
    task automatic t_soft_clear();
        expect_reg("live filter", cmp_pkg::OFF_STATUS, 32'h00000003);
        ahb(1'b1, cmp_pkg::OFF_STS_CLR, 32'h00000001);
        edges(1);
        check_bit("re-set after clear", 1'b1, latch);
        comp <= 1'b0;
        edges(20);
        check_bit("latch holds", 1'b1, latch);
        settle_clear();
        edges(10);
        check_bit("clean clear", 1'b0, latch);
    endtask
    task automatic t_flush();
        comp <= 1'b1;
        edges(4);
        ahb(1'b1, cmp_pkg::OFF_FILT_CTRL, 32'h00010304);
        ahb(1'b0, cmp_pkg::OFF_STATUS, 32'h00000000);
        check_bit("filter flushed", 1'b0, rd[cmp_pkg::STS_FILT_BIT]);
        expect_reg("filter ctrl", cmp_pkg::OFF_FILT_CTRL, 32'h00000304);
        comp <= 1'b0;
    endtask
    task automatic t_latency();
        logic [7:0] pre [2];
        logic [4:0] thr [2];
        int n;
        int lat;
        pre = '{8'h02, 8'h01};
        thr = '{5'h03, 5'h01};
        for (int i = 0; i < 2; i++)
        begin
            lat = 1 + pre[i] + thr[i] * pre[i];
            ahb(1'b1, cmp_pkg::OFF_FILT_CTRL, {15'h0000, 1'b1, 3'h0, thr[i], pre[i]});
            settle_clear();
            edges(2);
            @(posedge clk);
            comp <= 1'b1;
            n = 0;
            do
            begin
                edges(1);
                n++;
            end
            while (latch !== 1'b1 && n < 40);
            check_bit("trip within latency", 1'b1, n <= lat);
            comp <= 1'b0;
        end
    endtask
    // Trip dropped a full latency ahead of the sync, so the sync clear sticks
    task automatic t_sync_clear();
        check_bit("latch before sync", 1'b1, latch);
        comp <= 1'b0;
        edges(4);
        pulse_sync();
        check_bit("sync clears latch", 1'b0, latch);
        edges(4);
        check_bit("sync clear holds", 1'b0, latch);
    endtask
    task automatic t_glitch();
        settle_clear();
        @(posedge clk);
        comp <= 1'b1;
        @(posedge clk);
        comp <= 1'b0;
        edges(10);
        check_bit("glitch filtered", 1'b0, latch);
    endtask
    task automatic t_irq();
        expect_reg("irq status", cmp_pkg::OFF_IRQ_STS, 32'h00000003);
        ahb(1'b1, cmp_pkg::OFF_IRQ_EN, 32'h00000001);
        edges(1);
        check_bit("irq enabled", 1'b1, irq);
        expect_reg("irq enable", cmp_pkg::OFF_IRQ_EN, 32'h00000001);
        ahb(1'b1, cmp_pkg::OFF_IRQ_EN, 32'h00000000);
        edges(1);
        check_bit("irq masked", 1'b0, irq);
        ahb(1'b1, cmp_pkg::OFF_IRQ_EN, 32'h00000001);
        ahb(1'b1, cmp_pkg::OFF_IRQ_CLR, 32'h00000003);
        edges(1);
        check_bit("irq cleared", 1'b0, irq);
        expect_reg("irq status clear", cmp_pkg::OFF_IRQ_STS, 32'h00000000);
    endtask

    // ------------------------------------------------------------
    // Verdict
    // ------------------------------------------------------------
    task automatic summarize();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        rst_n = 1'b0;
        hsel = 1'b1;
        htrans = 2'h0;
        haddr = 32'h00000000;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h00000000;
        comp = 1'b0;
        req = 1'b0;
        failures = 0;
        total_checks = 0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        edges(1);
        t_reset();
        t_ramp();
        t_trip_hold();
        t_sync_wins();
        t_soft_clear();
        t_flush();
        t_latency();
        t_sync_clear();
        t_glitch();
        t_irq();
        summarize();
    end
endmodule // comparator_trip_latch_and_ramp_tb
`default_nettype wire
